// ===== rtl/eag_pkg.sv
package eag_pkg;

  // ---------------------------------------------------------------------------
  // Widths and field sizes
  // ---------------------------------------------------------------------------
  localparam int ADDR_W      = 16;
  localparam int REG_SEL_W   = 3;
  localparam int FREG_SEL_W  = 2;
  localparam int COND_W      = 3;
  localparam int DISP_W      = 8;
  localparam int SHORT_W     = 5;

  // ---------------------------------------------------------------------------
  // Address modes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] AM_REG      = 2'h0;
  localparam logic [1:0] AM_REG_INC  = 2'h1;
  localparam logic [1:0] AM_REG_WORD = 2'h2;
  localparam logic [1:0] AM_INDIRECT = 2'h3;

  // Forms of the indirect mode (address_mode_field = 11).
  localparam logic [1:0] IND_PLAIN   = 2'h0;
  localparam logic [1:0] IND_DISP    = 2'h1;
  localparam logic [1:0] IND_DOUBLE  = 2'h2;

  // Request kinds.
  localparam logic [2:0] KIND_LONG   = 3'h0;
  localparam logic [2:0] KIND_SHORT  = 3'h1;
  localparam logic [2:0] KIND_JUMP   = 3'h2;
  localparam logic [2:0] KIND_SHIFT1 = 3'h3;
  localparam logic [2:0] KIND_SHIFT2 = 3'h4;
  localparam logic [2:0] KIND_BITF   = 3'h5;

  // Operand size codes; the byte count is 1 << code.
  localparam logic [1:0] SZ_BYTE     = 2'h0;
  localparam logic [1:0] SZ_WORD     = 2'h1;
  localparam logic [1:0] SZ_DWORD    = 2'h2;

  // ---------------------------------------------------------------------------
  // Range limits
  // ---------------------------------------------------------------------------
  localparam logic signed [15:0] JUMP_MIN   = -16'sd256;
  localparam logic signed [15:0] JUMP_MAX   = 16'sd254;
  localparam logic [5:0]         SHIFT1_MAX = 6'h10;
  localparam logic [5:0]         SHIFT2_MAX = 6'h1F;
  localparam logic [6:0]         BITF_MAX   = 7'h3F;

  localparam logic [15:0] ADDR_RESET = 16'h0000;

  typedef enum logic [1:0] {
    EAG_IDLE  = 2'b00,
    EAG_FETCH = 2'b01,
    EAG_DONE  = 2'b10
  } eag_state_t;

endpackage : eag_pkg

// ===== rtl/eag_adder.sv
`timescale 1ns/1ps
// Modulo 2^W adder used for the base address sum; the double-form second sum is made outside it.
module eag_adder #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  output logic      [W-1:0] sum
);

  always_comb begin
    sum = a + b;
  end

endmodule : eag_adder

// ===== rtl/eag_effective_address.sv
`timescale 1ns/1ps
// Overview of operation
// - Mode 00 uses selected register contents directly as effective address.
// - Mode 01 uses register, then adds operand byte count to it.
// - Mode 10 adds sixteen-bit appended word to register one to seven.
// - Mode 11 plain form reads storage at register, uses word as address.
// - Mode 11 indexed form fetches word at register plus byte displacement.
// - Double form fetches at register plus displacement, then adds second byte offset to the word.
// - Byte operands may be odd; word and doubleword need even addresses.
// - Jump target is next byte plus signed displacement, -256 to +254.
// - Single shifts accept counts 0 to 16; pair shifts 0 to 31.
// - Condition operand is three bits choosing one of eight conditions.
// - Bit-field displacement accepted from 0 through 63.
// - Register selector addresses eight registers; some forms limit base register.
// - Floating register selector addresses four registers, zero to three.
// - Short form adds even displacement 0 to 62, optional one indirection.
// - Immediate byte is eight bits, read signed or unsigned.
// - Byte displacement with register is unsigned, 0 to 255.
// - Direct addresses and appended words are sixteen bits wide.
module eag_effective_address #(
  parameter int NUM_REGS = 8
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Request.
  input  wire logic        req_valid,
  input  wire logic [2:0]  req_kind,
  input  wire logic [1:0]  address_mode_field,
  input  wire logic [1:0]  indirect_form,
  input  wire logic        short_indirect,
  input  wire logic [2:0]  reg_sel,
  input  wire logic [1:0]  operand_size,
  input  wire logic [15:0] appended_word,
  input  wire logic [7:0]  byte_disp,
  input  wire logic [7:0]  second_byte_offset,
  input  wire logic [4:0]  short_word_disp,
  input  wire logic [15:0] next_instr_addr,
  input  wire logic [15:0] jump_disp,
  input  wire logic [5:0]  single_shift_count,
  input  wire logic [5:0]  pair_shift_count,
  input  wire logic [6:0]  bit_disp,
  input  wire logic [2:0]  cond_code,
  input  wire logic [1:0]  freg_sel,
  input  wire logic [7:0]  immediate_byte,
  // Register file port.
  output logic [2:0]       reg_rd_sel,
  input  wire logic [15:0] reg_rd_data,
  // Storage read port.
  output logic             mem_rd_req,
  output logic [15:0]      mem_rd_addr,
  input  wire logic        mem_rd_ack,
  input  wire logic [15:0] mem_rd_data,
  // Results.
  output logic             done,
  output logic [15:0]      eff_addr,
  output logic             addr_fault,
  output logic             range_fault,
  output logic             reg_wr_en,
  output logic [2:0]       reg_wr_sel,
  output logic [15:0]      reg_wr_data,
  output logic [7:0]       cond_onehot,
  output logic [3:0]       freg_onehot,
  output logic signed [15:0] imm_signed,
  output logic [15:0]      imm_unsigned
);

  // ---------------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------------
  if (NUM_REGS != 8) begin : g_bad_regs
    $error("NUM_REGS must be 8");
  end

  // ---------------------------------------------------------------------------
  // Address arithmetic
  // ---------------------------------------------------------------------------
  logic [15:0] base_opnd;
  logic [15:0] base_sum;
  logic [15:0] post_opnd;
  logic [15:0] post_sum;
  logic [15:0] fetched_r;
  logic [15:0] fetched_nxt;
  logic [15:0] size_bytes;

  always_comb begin
    reg_rd_sel = reg_sel;
    size_bytes = (operand_size == eag_pkg::SZ_BYTE) ? 16'h0001 :
                 (operand_size == eag_pkg::SZ_WORD) ? 16'h0002 : 16'h0004;
    base_opnd  = 16'h0000;
    if (req_kind == eag_pkg::KIND_SHORT) begin
      base_opnd = {10'h000, short_word_disp, 1'b0};
    end else if (req_kind == eag_pkg::KIND_JUMP) begin
      base_opnd = jump_disp;
    end else begin
      case (address_mode_field)
        eag_pkg::AM_REG_INC:  base_opnd = size_bytes;
        eag_pkg::AM_REG_WORD: base_opnd = appended_word;
        eag_pkg::AM_INDIRECT: begin
          if (indirect_form == eag_pkg::IND_PLAIN) begin
            base_opnd = 16'h0000;
          end else begin
            base_opnd = {8'h00, byte_disp};
          end
        end
        default:              base_opnd = 16'h0000;
      endcase
    end
    post_opnd = {8'h00, second_byte_offset};
  end

  eag_adder #(.W(eag_pkg::ADDR_W)) u_base_add (
    .a   ((req_kind == eag_pkg::KIND_JUMP) ? next_instr_addr : reg_rd_data),
    .b   (base_opnd),
    .sum (base_sum)
  );

  eag_adder #(.W(eag_pkg::ADDR_W)) u_post_add (
    .a   (fetched_r),
    .b   (post_opnd),
    .sum (post_sum)
  );

  // ---------------------------------------------------------------------------
  // Control
  // ---------------------------------------------------------------------------
  eag_pkg::eag_state_t state_r;
  eag_pkg::eag_state_t state_nxt;
  logic [15:0] eff_addr_nxt;
  logic        done_nxt;
  logic        addr_fault_nxt;
  logic        range_fault_nxt;
  logic        reg_wr_en_nxt;
  logic [15:0] reg_wr_data_nxt;
  logic        mem_rd_req_nxt;
  logic [15:0] mem_rd_addr_nxt;
  logic        need_fetch;
  logic        bad_base;
  logic        range_bad;
  logic        is_addr_kind;
  logic [15:0] direct_ea;
  logic signed [15:0] jd;

  always_comb begin
    jd           = jump_disp;
    is_addr_kind = (req_kind == eag_pkg::KIND_LONG) || (req_kind == eag_pkg::KIND_SHORT);
    need_fetch   = ((req_kind == eag_pkg::KIND_LONG) &&
                    (address_mode_field == eag_pkg::AM_INDIRECT)) ||
                   ((req_kind == eag_pkg::KIND_SHORT) && short_indirect);
    // Register one to seven base for modes 10 and 11; zero to three for modes 00, 01 and short.
    bad_base = ((req_kind == eag_pkg::KIND_LONG) && address_mode_field[1] &&
                (reg_sel == 3'h0)) ||
               ((req_kind == eag_pkg::KIND_LONG) && !address_mode_field[1] &&
                reg_sel[2]) ||
               ((req_kind == eag_pkg::KIND_SHORT) && reg_sel[2]);
    range_bad = 1'b0;
    case (req_kind)
      eag_pkg::KIND_JUMP:   range_bad = (jd < eag_pkg::JUMP_MIN) ||
                                        (jd > eag_pkg::JUMP_MAX) || jd[0];
      eag_pkg::KIND_SHIFT1: range_bad = single_shift_count > eag_pkg::SHIFT1_MAX;
      eag_pkg::KIND_SHIFT2: range_bad = pair_shift_count > eag_pkg::SHIFT2_MAX;
      eag_pkg::KIND_BITF:   range_bad = bit_disp > eag_pkg::BITF_MAX;
      default:              range_bad = 1'b0;
    endcase
    // Post-increment and plain register modes address the register itself.
    direct_ea = ((req_kind == eag_pkg::KIND_LONG) &&
                 (address_mode_field[1] == 1'b0)) ? reg_rd_data : base_sum;

    state_nxt       = state_r;
    eff_addr_nxt    = eff_addr;
    done_nxt        = 1'b0;
    addr_fault_nxt  = addr_fault;
    range_fault_nxt = range_fault;
    reg_wr_en_nxt   = 1'b0;
    reg_wr_data_nxt = reg_wr_data;
    mem_rd_req_nxt  = 1'b0;
    mem_rd_addr_nxt = mem_rd_addr;
    fetched_nxt     = fetched_r;

    case (state_r)
      eag_pkg::EAG_IDLE: begin
        if (req_valid) begin
          addr_fault_nxt  = 1'b0;
          range_fault_nxt = range_bad || (is_addr_kind && bad_base);
          if (need_fetch && !(is_addr_kind && bad_base)) begin
            mem_rd_req_nxt  = 1'b1;
            mem_rd_addr_nxt = base_sum;
            state_nxt       = eag_pkg::EAG_FETCH;
          end else begin
            eff_addr_nxt = direct_ea;
            addr_fault_nxt = is_addr_kind && direct_ea[0] &&
                             (operand_size != eag_pkg::SZ_BYTE);
            if ((req_kind == eag_pkg::KIND_LONG) &&
                (address_mode_field == eag_pkg::AM_REG_INC)) begin
              reg_wr_en_nxt   = 1'b1;
              reg_wr_data_nxt = base_sum;
            end
            done_nxt  = 1'b1;
            state_nxt = eag_pkg::EAG_DONE;
          end
        end
      end
      eag_pkg::EAG_FETCH: begin
        mem_rd_req_nxt = !mem_rd_ack;
        if (mem_rd_ack) begin
          fetched_nxt = mem_rd_data;
          state_nxt   = eag_pkg::EAG_DONE;
          // The second offset is added in the answer cycle to the incoming word, not to the held word.
          if ((req_kind == eag_pkg::KIND_LONG) &&
              (indirect_form == eag_pkg::IND_DOUBLE)) begin
            eff_addr_nxt = mem_rd_data + {8'h00, second_byte_offset};
          end else begin
            eff_addr_nxt = mem_rd_data;
          end
          addr_fault_nxt = eff_addr_nxt[0] && (operand_size != eag_pkg::SZ_BYTE);
          done_nxt = 1'b1;
        end
      end
      eag_pkg::EAG_DONE: begin
        state_nxt = eag_pkg::EAG_IDLE;
      end
      default: begin
        state_nxt = eag_pkg::EAG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r     <= eag_pkg::EAG_IDLE;
      eff_addr    <= eag_pkg::ADDR_RESET;
      done        <= 1'b0;
      addr_fault  <= 1'b0;
      range_fault <= 1'b0;
      reg_wr_en   <= 1'b0;
      reg_wr_sel  <= 3'h0;
      reg_wr_data <= eag_pkg::ADDR_RESET;
      mem_rd_req  <= 1'b0;
      mem_rd_addr <= eag_pkg::ADDR_RESET;
      fetched_r   <= eag_pkg::ADDR_RESET;
    end else begin
      state_r     <= state_nxt;
      eff_addr    <= eff_addr_nxt;
      done        <= done_nxt;
      addr_fault  <= addr_fault_nxt;
      range_fault <= range_fault_nxt;
      reg_wr_en   <= reg_wr_en_nxt;
      reg_wr_sel  <= reg_sel;
      reg_wr_data <= reg_wr_data_nxt;
      mem_rd_req  <= mem_rd_req_nxt;
      mem_rd_addr <= mem_rd_addr_nxt;
      fetched_r   <= fetched_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Operand field decode
  // ---------------------------------------------------------------------------
  logic [7:0]  cond_onehot_nxt;
  logic [3:0]  freg_onehot_nxt;

  always_comb begin
    cond_onehot_nxt = 8'h01 << cond_code;
    freg_onehot_nxt = 4'h1 << freg_sel;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cond_onehot  <= 8'h00;
      freg_onehot  <= 4'h0;
      imm_signed   <= 16'sh0000;
      imm_unsigned <= 16'h0000;
    end else begin
      cond_onehot  <= cond_onehot_nxt;
      freg_onehot  <= freg_onehot_nxt;
      imm_signed   <= {{8{immediate_byte[7]}}, immediate_byte};
      imm_unsigned <= {8'h00, immediate_byte};
    end
  end

endmodule : eag_effective_address

// ===== sim/eag_monitor.sv
`timescale 1ns/1ps
module eag_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [2:0]  req_kind,
  input wire logic [1:0]  address_mode_field,
  input wire logic [1:0]  operand_size,
  input wire logic [15:0] appended_word,
  input wire logic [15:0] next_instr_addr,
  input wire logic [15:0] jump_disp,
  input wire logic [2:0]  cond_code,
  input wire logic [15:0] reg_rd_data,
  input wire logic        mem_rd_req,
  input wire logic [15:0] mem_rd_addr,
  input wire logic        mem_rd_ack,
  input wire logic        done,
  input wire logic [15:0] eff_addr,
  input wire logic        addr_fault,
  input wire logic        range_fault,
  input wire logic        reg_wr_en,
  input wire logic [15:0] reg_wr_data,
  input wire logic [7:0]  cond_onehot
);
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic long_ok;
  assign long_ok = done && !range_fault && req_kind == eag_pkg::KIND_LONG;

  AST_DIRECT_EA: assert property (
    long_ok && address_mode_field == eag_pkg::AM_REG |-> eff_addr == reg_rd_data)
    else $error("direct mode address differs from register");
  AST_POSTINC_WR: assert property (
    long_ok && address_mode_field == eag_pkg::AM_REG_INC |->
      reg_wr_en && reg_wr_data == eff_addr + (16'h0001 << operand_size))
    else $error("post increment write missing or wrong");
  AST_WR_ONLY_DONE: assert property (reg_wr_en |-> done)
    else $error("register write without completion");
  AST_REG_WORD: assert property (
    long_ok && address_mode_field == eag_pkg::AM_REG_WORD |->
      eff_addr == reg_rd_data + appended_word)
    else $error("register plus word address wrong");
  AST_FETCH_DONE: assert property (mem_rd_req && mem_rd_ack |=> done && !mem_rd_req)
    else $error("fetch answer not followed by completion");
  AST_FETCH_HOLD: assert property (
    mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr))
    else $error("storage request dropped or moved before answer");
  AST_ODD_WORD: assert property (
    long_ok && operand_size != eag_pkg::SZ_BYTE && eff_addr[0] |-> addr_fault)
    else $error("odd word address not flagged");
  AST_BYTE_ANY: assert property (done && operand_size == eag_pkg::SZ_BYTE |-> !addr_fault)
    else $error("byte address flagged");
  AST_JUMP_EA: assert property (
    done && !range_fault && req_kind == eag_pkg::KIND_JUMP |->
      eff_addr == next_instr_addr + jump_disp)
    else $error("jump target wrong");
  AST_COND_DEC: assert property (
    !$past(sys_rst) |-> cond_onehot == (8'h01 << $past(cond_code)))
    else $error("condition decode wrong");

  cover property (mem_rd_req && mem_rd_ack);
  cover property (reg_wr_en);
  cover property (done && range_fault);
  cover property (done && addr_fault);
endmodule : eag_monitor

bind eag_effective_address eag_monitor mon_u (
  .clk, .sys_rst, .req_kind, .address_mode_field, .operand_size, .appended_word,
  .next_instr_addr, .jump_disp, .cond_code, .reg_rd_data, .mem_rd_req, .mem_rd_addr,
  .mem_rd_ack, .done, .eff_addr, .addr_fault, .range_fault, .reg_wr_en, .reg_wr_data,
  .cond_onehot
);

// ===== sim/eag_mem_model.sv
`timescale 1ns/1ps
module eag_mem_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        mem_rd_req,
  input  wire logic [15:0] mem_rd_addr,
  input  wire logic [3:0]  wait_cycles,
  output logic             mem_rd_ack,
  output logic [15:0]      mem_rd_data
);
  logic [3:0] cnt_r;
  // Between answers the data toggles, so a stale read can never pass for a valid one.
  always_ff @(posedge clk) begin
    if (sys_rst || !mem_rd_req || mem_rd_ack) begin
      cnt_r       <= 4'h0;
      mem_rd_ack  <= 1'b0;
      mem_rd_data <= sys_rst ? 16'h0000 : ~mem_rd_data;
    end else if (cnt_r >= wait_cycles) begin
      mem_rd_ack  <= 1'b1;
      mem_rd_data <= mem_rd_addr ^ 16'ha5c3;
    end else begin
      cnt_r       <= cnt_r + 4'h1;
      mem_rd_data <= ~mem_rd_data;
    end
  end
endmodule : eag_mem_model

// ===== sim/effective_address_generator_tb_top.sv
`timescale 1ns/1ps
module effective_address_generator_tb_top;
  logic        clk, sys_rst, req_valid, short_indirect, mem_rd_req, mem_rd_ack, done;
  logic        addr_fault, range_fault, reg_wr_en;
  logic [1:0]  address_mode_field, indirect_form, operand_size, freg_sel;
  logic [2:0]  req_kind, reg_sel, cond_code, reg_rd_sel, reg_wr_sel;
  logic [3:0]  wait_cycles;
  logic [4:0]  short_word_disp;
  logic [5:0]  single_shift_count, pair_shift_count;
  logic [6:0]  bit_disp;
  logic [7:0]  byte_disp, second_byte_offset, immediate_byte;
  logic [15:0] appended_word, next_instr_addr, jump_disp, mem_rd_addr, mem_rd_data;
  logic [15:0] eff_addr, reg_wr_data, reg_rd_data, regs [8];
  logic [7:0]  cond_onehot;
  logic [3:0]  freg_onehot;
  logic [15:0] imm_signed, imm_unsigned;
  logic [15:0] jcorner [4] = '{16'hff00, 16'h00fe, 16'h0100, 16'hfefe};
  int          fails, n_compared;
  int          cyc = 0;

  assign reg_rd_data = regs[reg_rd_sel];

  eag_effective_address #(.NUM_REGS(8)) dut_u (
    .clk, .sys_rst, .req_valid, .req_kind, .address_mode_field, .indirect_form, .short_indirect,
    .reg_sel, .operand_size, .appended_word, .byte_disp, .second_byte_offset, .short_word_disp,
    .next_instr_addr, .jump_disp, .single_shift_count, .pair_shift_count, .bit_disp, .cond_code,
    .freg_sel, .immediate_byte, .reg_rd_sel, .reg_rd_data, .mem_rd_req, .mem_rd_addr,
    .mem_rd_ack, .mem_rd_data, .done, .eff_addr, .addr_fault, .range_fault, .reg_wr_en,
    .reg_wr_sel, .reg_wr_data, .cond_onehot, .freg_onehot, .imm_signed, .imm_unsigned
  );

  eag_mem_model mem_u (
    .clk, .sys_rst, .mem_rd_req, .mem_rd_addr, .wait_cycles, .mem_rd_ack, .mem_rd_data
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (reg_wr_en) regs[reg_wr_sel] <= reg_wr_data;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  function automatic logic [15:0] mem_word(input logic [15:0] x);
    return x ^ 16'ha5c3;
  endfunction : mem_word

  task automatic close_out;
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic drive(input int i);
    req_kind           <= 3'(i % 6);
    address_mode_field <= 2'($urandom);
    indirect_form      <= 2'($urandom_range(0, 2));
    short_indirect     <= 1'($urandom);
    reg_sel            <= 3'($urandom);
    operand_size       <= 2'($urandom_range(0, 2));
    appended_word      <= 16'($urandom);
    byte_disp          <= 8'($urandom);
    second_byte_offset <= 8'($urandom);
    short_word_disp    <= 5'($urandom);
    next_instr_addr    <= 16'($urandom);
    jump_disp          <= (i < 24) ? jcorner[i / 6] : 16'($urandom_range(0, 600) - 300);
    single_shift_count <= 6'($urandom_range(0, 18));
    pair_shift_count   <= 6'($urandom_range(0, 33));
    bit_disp           <= 7'($urandom_range(0, 66));
    cond_code          <= 3'($urandom);
    freg_sel           <= 2'($urandom);
    immediate_byte     <= 8'($urandom);
    wait_cycles        <= 4'($urandom_range(0, 5));
  endtask : drive

  task automatic run_one(input int i);
    logic [15:0] r, a;
    logic        rf;
    int          n;
    repeat (2) @(posedge clk);
    drive(i);
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    #1;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 40) begin
      fails++;
      $display("[FAIL] done expected 1 seen %b", done);
    end
    r  = regs[reg_sel];
    a  = r;
    rf = 1'b0;
    case (req_kind)
      eag_pkg::KIND_LONG: begin
        rf = address_mode_field[1] ? (reg_sel == 3'h0) : (reg_sel > 3'h3);
        if (address_mode_field == eag_pkg::AM_REG_WORD) a = r + appended_word;
        if (address_mode_field == eag_pkg::AM_INDIRECT) begin
          if (indirect_form != eag_pkg::IND_PLAIN) a = r + {8'h00, byte_disp};
          a = mem_word(a);
          if (indirect_form == eag_pkg::IND_DOUBLE) a = a + {8'h00, second_byte_offset};
        end
      end
      eag_pkg::KIND_SHORT: begin
        rf = reg_sel > 3'h3;
        a  = r + {10'h000, short_word_disp, 1'b0};
        if (short_indirect) a = mem_word(a);
      end
      eag_pkg::KIND_JUMP: begin
        a  = next_instr_addr + jump_disp;
        rf = jump_disp[0] || ($signed(jump_disp) < eag_pkg::JUMP_MIN)
             || ($signed(jump_disp) > eag_pkg::JUMP_MAX);
      end
      eag_pkg::KIND_SHIFT1: rf = single_shift_count > eag_pkg::SHIFT1_MAX;
      eag_pkg::KIND_SHIFT2: rf = pair_shift_count > eag_pkg::SHIFT2_MAX;
      default: rf = bit_disp > eag_pkg::BITF_MAX;
    endcase
    check("range_fault", 16'(rf), 16'(range_fault));
    check("cond_onehot", 16'(8'h01 << cond_code), 16'(cond_onehot));
    check("freg_onehot", 16'(4'h1 << freg_sel), 16'(freg_onehot));
    check("imm_signed", 16'($signed(immediate_byte)), imm_signed);
    check("imm_unsigned", {8'h00, immediate_byte}, imm_unsigned);
    if (!rf && req_kind <= eag_pkg::KIND_JUMP) check("eff_addr", a, eff_addr);
    if (!rf && req_kind <= eag_pkg::KIND_SHORT)
      check("addr_fault", 16'(operand_size != eag_pkg::SZ_BYTE && a[0]), 16'(addr_fault));
    if (!rf && req_kind == eag_pkg::KIND_LONG && address_mode_field == eag_pkg::AM_REG_INC) begin
      @(posedge clk);
      #1;
      check("post_inc", r + (16'h0001 << operand_size), regs[reg_sel]);
    end
  endtask : run_one

  initial begin
    void'($urandom(32'hd7f8));
    fails      = 0;
    n_compared = 0;
    sys_rst    = 1'b1;
    req_valid  = 1'b0;
    foreach (regs[k]) regs[k] = 16'($urandom);
    drive(0);
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 400; i++) run_one(i);
    close_out();
  end
endmodule : effective_address_generator_tb_top
